// ### logic/wdt_params.svh
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// Register map, byte addresses on the 32-bit bus
`define WDT_ADDR_W 8
`define WDT_CTL_ADDR 8'h00
`define WDT_STS_ADDR 8'h04
`define WDT_CNT_ADDR 8'h08

// Control register layout and reset value
`define WDT_CTL_RESET 8'h16
`define WDT_PS_MSB 5
`define WDT_PS_LSB 1
`define WDT_SWEN_BIT 0

// Status register layout
`define WDT_STS_TIMEOUT_BIT 0
`define WDT_STS_POWERDOWN_BIT 1
`define WDT_STS_ACTIVE_BIT 2
`define WDT_STS_SLEEP_BIT 3

// Prescaler
`define WDT_CNT_W 24
`define WDT_PS_MAX_CODE 5'h12
`define WDT_PS_MIN_CODE 5'h00
`define WDT_BASE_PRESCALE 24'h000020
`define WDT_LF_HZ 31000

// Bus responses
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// ### logic/wdt_pkg.sv
package wdt_pkg;

    typedef enum logic [1:0] {
        wdt_mode_off = 2'b00,
        wdt_mode_soft = 2'b01,
        wdt_mode_nosleep = 2'b10,
        wdt_mode_on = 2'b11
    } wdt_mode_t;

    typedef struct packed {
        logic [1:0] unused;
        logic [4:0] period_select;
        logic soft_enable_bit;
    } wdt_ctl_t;

    typedef struct packed {
        wdt_mode_t watchdog_mode_cfg;
        logic in_sleep;
        logic clear_instruction;
        logic osc_fail;
        logic osc_startup_timer;
    } wdt_sys_in_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wdt_wr_t;

endpackage

// ### logic/wdt_lf_sync.sv
`timescale 1ns/1ps
module wdt_lf_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic lf_osc,
    output logic lf_tick
);
    logic sync_a;
    logic sync_b;
    logic sync_c;

    // sync_b and sync_c feed the edge detector; sync_a is left to settle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            lf_tick <= 1'b0;
        end else begin
            sync_a <= lf_osc;
            sync_b <= sync_a;
            sync_c <= sync_b;
            lf_tick <= sync_b & ~sync_c;
        end
    end
endmodule

// ### logic/wdt_axil.sv
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_axil (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wr_hit,
    input wire logic rd_hit,
    input wire logic [31:0] rd_word,
    output wdt_pkg::wdt_wr_t wr,
    output logic wr_fire
);
    import wdt_pkg::*;

    logic aw_got;
    logic w_got;
    logic next_aw_got;
    logic next_w_got;
    logic next_bvalid;
    logic next_rvalid;
    logic ar_take;

    assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;

    always_comb begin
        next_aw_got = wr_fire ? 1'b0 : (aw_got | (s_axi_awvalid & s_axi_awready));
        next_w_got = wr_fire ? 1'b0 : (w_got | (s_axi_wvalid & s_axi_wready));
        next_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);
        next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
    end

    // Ready flags are registered so every bus output leaves a flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WDT_RESP_OKAY;
            wr <= '0;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            s_axi_bvalid <= next_bvalid;
            s_axi_awready <= ~next_aw_got & ~next_bvalid;
            s_axi_wready <= ~next_w_got & ~next_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                wr.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr.data <= s_axi_wdata;
                wr.strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bresp <= wr_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `WDT_RESP_OKAY;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_arready <= ~next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
            end
        end
    end
endmodule

// ### logic/wdt_top.sv
// Behaviour
// - Counter advances only on ticks of the 31 kHz low-frequency oscillator.
// - Base prescale of 32 ticks gives about 1 ms at the lowest setting.
// - Mode 11 keeps the watchdog active always, Sleep included.
// - Mode 10 keeps it active when awake, disabled in Sleep.
// - Mode 01 follows only the software enable bit, in Sleep as when awake.
// - In mode 01, enable bit 1 turns it on, 0 turns it off.
// - Modes 00 and 1x ignore the enable bit; mode 00 is always off.
// - Period select in bits 5:1; code 0 is 1:32, doubling to 1:8388608.
// - Codes 10011 to 11111 act as the minimum prescale 1:32.
// - After reset period select holds 01011, prescale 1:65536.
// - Count cleared on reset, clear, Sleep entry/exit, osc fail, disable, start-up.
// - Sleep entry clears the count; counting then resumes from zero if enabled.
// - Sleep exit clears again; count held clear while start-up timer runs.
// - Time-out in Sleep makes no reset; it wakes and updates status flags.
// - Fast oscillator divider changes do not touch the count.
// - Control bits 7:6 ignore writes and read as zero.
// - Time-out while awake and active requests a device reset.
// - Time-out wake sets the time-out flag and clears the power-down flag.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic low_freq_internal_osc,
    input wire wdt_pkg::wdt_sys_in_t sys,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wdt_reset_req,
    output logic wdt_wake,
    output logic timeout_flag,
    output logic powerdown_flag
);
    import wdt_pkg::*;

    logic lf_tick;
    wdt_wr_t wr;
    logic wr_fire;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;
    wdt_ctl_t ctl;
    logic [`WDT_CNT_W-1:0] count;
    logic [`WDT_CNT_W-1:0] target;
    logic clear_pend;
    logic in_sleep_d;
    logic active;
    logic timeout;
    logic sleep_entry;
    logic sleep_exit;
    logic clear_event;
    logic clear_now;
    logic ctl_write;
    logic sts_write;

    // Reserved codes fall back to the shortest interval
    function automatic logic [`WDT_CNT_W-1:0] prescale_span(input logic [4:0] ps);
        logic [4:0] code;
        code = (ps > `WDT_PS_MAX_CODE) ? `WDT_PS_MIN_CODE : ps;
        return `WDT_BASE_PRESCALE << code;
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        return (a == `WDT_CTL_ADDR) || (a == `WDT_STS_ADDR) || (a == `WDT_CNT_ADDR);
    endfunction

    wdt_lf_sync u_lf_sync (
        .clk(clk),
        .reset_n(reset_n),
        .lf_osc(low_freq_internal_osc),
        .lf_tick(lf_tick)
    );

    wdt_axil u_axil (
        .clk(clk),
        .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_hit(wr_hit),
        .rd_hit(rd_hit),
        .rd_word(rd_word),
        .wr(wr),
        .wr_fire(wr_fire)
    );

    assign wr_hit = reg_mapped(wr.addr);
    assign rd_hit = reg_mapped(s_axi_araddr);
    assign ctl_write = wr_fire && (wr.addr == `WDT_CTL_ADDR) && wr.strb[0];
    assign sts_write = wr_fire && (wr.addr == `WDT_STS_ADDR) && wr.strb[0];

    always_comb begin
        unique case (sys.watchdog_mode_cfg)
            wdt_mode_on: active = 1'b1;
            wdt_mode_nosleep: active = ~sys.in_sleep;
            wdt_mode_soft: active = ctl.soft_enable_bit;
            wdt_mode_off: active = 1'b0;
        endcase
    end

    assign sleep_entry = sys.in_sleep & ~in_sleep_d;
    assign sleep_exit = ~sys.in_sleep & in_sleep_d;
    // A disabled watchdog keeps a clear pending, so re-enabling starts from zero
    assign clear_event = sys.clear_instruction | sleep_entry | sleep_exit | sys.osc_fail
        | sys.osc_startup_timer | ~active;
    // A clear landing on the tick itself also counts, so a late clear is never outrun
    assign clear_now = clear_pend | clear_event;

    assign target = prescale_span(ctl.period_select);
    assign timeout = lf_tick && active && !clear_now
        && (`WDT_CNT_W'(count + 1'b1) == target);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_sleep_d <= 1'b0;
        end else begin
            in_sleep_d <= sys.in_sleep;
        end
    end

    // Clears are only honoured on a tick; the set wins over the tick's release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clear_pend <= 1'b1;
        end else if (clear_event) begin
            clear_pend <= 1'b1;
        end else if (lf_tick) begin
            clear_pend <= 1'b0;
        end
    end

    // The count sees no fast-oscillator divider input, so divider changes leave it alone
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (lf_tick) begin
            if (clear_now) begin
                count <= '0;
            end else if (timeout) begin
                count <= '0;
            end else if (active) begin
                count <= `WDT_CNT_W'(count + 1'b1);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl <= `WDT_CTL_RESET;
        end else if (ctl_write) begin
            ctl.period_select <= wr.data[`WDT_PS_MSB:`WDT_PS_LSB];
            ctl.soft_enable_bit <= wr.data[`WDT_SWEN_BIT];
            ctl.unused <= 2'b00;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdt_reset_req <= 1'b0;
            wdt_wake <= 1'b0;
        end else begin
            wdt_reset_req <= timeout & ~sys.in_sleep;
            wdt_wake <= timeout & sys.in_sleep;
        end
    end

    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timeout_flag <= 1'b0;
        end else if (timeout) begin
            timeout_flag <= 1'b1;
        end else if (sts_write && wr.data[`WDT_STS_TIMEOUT_BIT]) begin
            timeout_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            powerdown_flag <= 1'b0;
        end else if (timeout && sys.in_sleep) begin
            powerdown_flag <= 1'b0;
        end else if (sleep_entry) begin
            powerdown_flag <= 1'b1;
        end else if (sts_write && wr.data[`WDT_STS_POWERDOWN_BIT]) begin
            powerdown_flag <= 1'b0;
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        case (s_axi_araddr)
            `WDT_CTL_ADDR: rd_word = {24'h000000, 2'b00, ctl.period_select,
                ctl.soft_enable_bit};
            `WDT_STS_ADDR: begin
                rd_word[`WDT_STS_TIMEOUT_BIT] = timeout_flag;
                rd_word[`WDT_STS_POWERDOWN_BIT] = powerdown_flag;
                rd_word[`WDT_STS_ACTIVE_BIT] = active;
                rd_word[`WDT_STS_SLEEP_BIT] = sys.in_sleep;
            end
            `WDT_CNT_ADDR: rd_word = {8'h00, count};
            default: rd_word = 32'h00000000;
        endcase
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_sleep_timeout;
        timeout && sys.in_sleep;
    endsequence

    sequence s_wake_report;
        wdt_wake && !wdt_reset_req && timeout_flag && !powerdown_flag;
    endsequence

    sequence s_clear_then_tick;
        clear_event ##[1:6] lf_tick;
    endsequence

    a_always_on_mode: assert property (
        sys.watchdog_mode_cfg == wdt_mode_on |-> active)
        else $error("mode 11 left the watchdog inactive");

    a_nosleep_mode: assert property (
        sys.watchdog_mode_cfg == wdt_mode_nosleep |-> active == !sys.in_sleep)
        else $error("mode 10 activity does not follow sleep state");

    a_soft_mode: assert property (
        sys.watchdog_mode_cfg == wdt_mode_soft |-> active == ctl.soft_enable_bit)
        else $error("mode 01 activity does not follow enable bit");

    a_off_mode: assert property (
        sys.watchdog_mode_cfg == wdt_mode_off |-> !active && !timeout)
        else $error("mode 00 watchdog was active");

    a_reserved_code: assert property (
        ctl.period_select > `WDT_PS_MAX_CODE |-> target == `WDT_BASE_PRESCALE)
        else $error("reserved period code not at minimum prescale");

    a_clear_on_tick: assert property (
        s_clear_then_tick |=> count == '0)
        else $error("count not cleared at tick after clear event");

    a_startup_hold: assert property (
        sys.osc_startup_timer && lf_tick |=> count == '0)
        else $error("count moved while start-up timer runs");

    a_awake_reset: assert property (
        timeout && !sys.in_sleep |=> wdt_reset_req && !wdt_wake && timeout_flag)
        else $error("awake time-out did not request reset");

    a_sleep_wake: assert property (
        s_sleep_timeout |=> s_wake_report)
        else $error("sleep time-out did not wake with correct flags");

    a_timeout_span: assert property (
        timeout |-> `WDT_CNT_W'(count + 1'b1) == target ##1 count == '0)
        else $error("time-out not at selected span");

    a_reserved_bits: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `WDT_CTL_ADDR
        |=> s_axi_rvalid && s_axi_rdata[7:6] == 2'b00)
        else $error("control bits 7:6 read nonzero");

    a_flag_set_wins: assert property (
        timeout && sts_write |=> timeout_flag)
        else $error("time-out flag lost to a same-cycle clear");

    a_entry_clears: assert property (
        sleep_entry |=> clear_pend)
        else $error("sleep entry left no clear pending");

    a_exit_clears: assert property (
        sleep_exit |=> clear_pend)
        else $error("sleep exit left no clear pending");

    a_osc_fail_clears: assert property (
        sys.osc_fail |=> clear_pend)
        else $error("oscillator failure left no clear pending");

    a_clear_blocks_timeout: assert property (
        sys.clear_instruction |=> !wdt_reset_req && !wdt_wake)
        else $error("time-out fired despite a clear");

    a_sleep_no_reset: assert property (
        sys.in_sleep |=> !wdt_reset_req)
        else $error("reset requested while asleep");

    a_reset_single: assert property (
        wdt_reset_req |=> !wdt_reset_req)
        else $error("reset request longer than one cycle");

    a_wake_single: assert property (
        wdt_wake |=> !wdt_wake)
        else $error("wake pulse longer than one cycle");

    a_count_steady: assert property (
        !lf_tick |=> $stable(count))
        else $error("count moved without a slow tick");

    a_count_advance: assert property (
        lf_tick && active && !clear_now && !timeout |=> count == $past(count) + 1'b1)
        else $error("count did not advance on a slow tick");

    a_upper_bits_zero: assert property (
        ctl.unused == 2'b00)
        else $error("unimplemented control bits hold ones");

    a_pd_on_entry: assert property (
        sleep_entry |=> powerdown_flag)
        else $error("power-down flag not set on sleep entry");

    a_aw_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open while a response is pending");

    a_ar_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while read data is pending");
endmodule

// ### sim/wdt_tb.sv
`timescale 1ns/1ps
module tb;
    import wdt_pkg::*;
    logic clk = 0;
    logic reset_n = 0;
    logic lf_osc = 0;
    wdt_sys_in_t sys = '0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] word;
    logic wdt_reset_req, wdt_wake, timeout_flag, powerdown_flag;
    int error_cnt = 0;
    int comparisons = 0;
    int rst_cnt = 0;
    int wake_cnt = 0;
    int i;
    logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1F};

    always #5 clk = ~clk;

    wdt_top dut (.clk(clk), .reset_n(reset_n), .low_freq_internal_osc(lf_osc), .sys(sys),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wdt_reset_req(wdt_reset_req),
        .wdt_wake(wdt_wake), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));

    // Pulses last one cycle, so they are tallied rather than polled
    always @(posedge clk) begin
        if (wdt_reset_req === 1'b1) rst_cnt++;
        if (wdt_wake === 1'b1) wake_cnt++;
    end

    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
            if (error_cnt == 0 && comparisons > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        begin
            comparisons++;
            if (seen !== exp) begin
                error_cnt++;
                $display("mismatch %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task hang(input string name);
        begin
            error_cnt++;
            $display("mismatch %s expected handshake seen none", name);
            print_verdict;
        end
    endtask

    // Both channels offered together; each released at its own handshake edge
    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw_done;
        logic w_done;
        begin
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hF;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            aw_done = 0;
            w_done = 0;
            for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
                @(posedge clk);
                if (!aw_done && awready === 1'b1) begin
                    aw_done = 1;
                    awvalid <= 0;
                end
                if (!w_done && wready === 1'b1) begin
                    w_done = 1;
                    wvalid <= 0;
                end
            end
            if (!(aw_done && w_done)) hang("write_addr_data");
            for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge clk);
            if (bvalid !== 1'b1) hang("write_resp");
            r = bresp;
            bready <= 0;
            // An idle edge keeps a following call from re-driving bready in one step
            @(posedge clk);
        end
    endtask

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        begin
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
            for (n = 0; n < 50; n++) begin
                @(posedge clk);
                if (arready === 1'b1) break;
            end
            if (arready !== 1'b1) hang("read_addr");
            arvalid <= 0;
            for (n = 0; n < 50; n++) begin
                @(posedge clk);
                if (rvalid === 1'b1) break;
            end
            if (rvalid !== 1'b1) hang("read_data");
            d = rdata;
            r = rresp;
            rready <= 0;
            @(posedge clk);
        end
    endtask

    // Each phase of the slow clock spans three fast cycles
    task tick(input int n);
        repeat (n) begin
            lf_osc <= 1;
            repeat (3) @(posedge clk);
            lf_osc <= 0;
            repeat (3) @(posedge clk);
        end
    endtask

    task pulse_clear;
        begin
            sys.clear_instruction <= 1;
            @(posedge clk);
            sys.clear_instruction <= 0;
            @(posedge clk);
        end
    endtask

    // One full period from a fresh clear; the first tick after a clear only zeroes
    task run_period(input logic [7:0] ctl, input int exp_rst, input int exp_wake);
        int target;
        int r0;
        int w0;
        begin
            target = (ctl[5:1] > 5'h12) ? 32 : (32 << ctl[5:1]);
            axi_write(8'h00, {24'h0, ctl}, resp);
            pulse_clear;
            tick(1);
            r0 = rst_cnt;
            w0 = wake_cnt;
            tick(target - 1);
            check("early_timeout", rst_cnt - r0 + wake_cnt - w0, 0);
            tick(1);
            check("reset_pulses", rst_cnt - r0, exp_rst);
            check("wake_pulses", wake_cnt - w0, exp_wake);
        end
    endtask

    initial begin
        sys.watchdog_mode_cfg <= wdt_mode_on;
        repeat (2) @(posedge clk);
        reset_n <= 1;
        repeat (2) @(posedge clk);
        axi_read(8'h00, word, resp);
        check("ctl_reset", word, 32'h16);
        axi_write(8'h00, 32'hFF, resp);
        axi_read(8'h00, word, resp);
        check("ctl_unimpl", word, 32'h3F);
        axi_read(8'h0C, word, resp);
        check("unmapped_rresp", {30'h0, resp}, 32'h2);
        check("unmapped_rdata", word, 32'h0);
        axi_write(8'h0C, 32'hFF, resp);
        check("unmapped_bresp", {30'h0, resp}, 32'h2);
        for (i = 0; i < 5; i++)
            run_period({2'b00, codes[i], 1'b0}, 1, 0);
        check("timeout_flag", timeout_flag, 1'b1);
        pulse_clear;
        tick(6);
        axi_read(8'h08, word, resp);
        check("count_ticks", word, 32'h5);
        repeat (40) @(posedge clk);
        axi_read(8'h08, word, resp);
        check("count_idle", word, 32'h5);
        reset_n <= 0;
        repeat (2) @(posedge clk);
        reset_n <= 1;
        repeat (2) @(posedge clk);
        axi_read(8'h00, word, resp);
        check("ctl_rereset", word, 32'h16);
        axi_read(8'h08, word, resp);
        check("count_rereset", word, 32'h0);
        tick(3);
        sys.osc_fail <= 1;
        @(posedge clk);
        sys.osc_fail <= 0;
        tick(1);
        axi_read(8'h08, word, resp);
        check("count_oscfail", word, 32'h0);
        tick(4);
        sys.osc_startup_timer <= 1;
        tick(3);
        axi_read(8'h08, word, resp);
        check("count_startup", word, 32'h0);
        sys.osc_startup_timer <= 0;
        sys.watchdog_mode_cfg <= wdt_mode_nosleep;
        run_period(8'h00, 1, 0);
        sys.in_sleep <= 1;
        tick(1);
        check("pd_on_sleep", powerdown_flag, 1'b1);
        axi_read(8'h04, word, resp);
        check("sts_sleep", word, 32'hB);
        run_period(8'h00, 0, 0);
        sys.in_sleep <= 0;
        sys.watchdog_mode_cfg <= wdt_mode_on;
        tick(1);
        axi_write(8'h04, 32'h3, resp);
        check("tflag_w1c", timeout_flag, 1'b0);
        axi_read(8'h04, word, resp);
        check("sts_w1c", word, 32'h4);
        sys.in_sleep <= 1;
        run_period(8'h00, 0, 1);
        check("tflag_wake", timeout_flag, 1'b1);
        check("pd_wake", powerdown_flag, 1'b0);
        sys.in_sleep <= 0;
        sys.watchdog_mode_cfg <= wdt_mode_soft;
        run_period(8'h00, 0, 0);
        run_period(8'h01, 1, 0);
        sys.in_sleep <= 1;
        run_period(8'h01, 0, 1);
        sys.in_sleep <= 0;
        sys.watchdog_mode_cfg <= wdt_mode_off;
        run_period(8'h01, 0, 0);
        print_verdict;
    end
endmodule
